// ==== src/tcu_pkg.sv ====
// constants for the 16-bit timer counter with input capture
// assumes a 125 MHz system clock and an axi4-lite register bus
package tcu_pkg;
    // --------------------------------------------------------------
    // register byte offsets
    // --------------------------------------------------------------
    localparam logic [5:0] OFF_COUNT_LO = 6'h00;
    localparam logic [5:0] OFF_COUNT_HI = 6'h04;
    localparam logic [5:0] OFF_CAPT_LO = 6'h08;
    localparam logic [5:0] OFF_CAPT_HI = 6'h0C;
    localparam logic [5:0] OFF_CTRL_A = 6'h10;
    localparam logic [5:0] OFF_CTRL_B = 6'h14;
    localparam logic [5:0] OFF_FLAGS = 6'h18;
    localparam logic [5:0] OFF_IRQ_EN = 6'h1C;
    localparam logic [5:0] OFF_CMP_CS = 6'h20;
    // --------------------------------------------------------------
    // field positions
    // --------------------------------------------------------------
    localparam int CB_CS_LSB = 0;
    localparam int CB_WGM_LSB = 3;
    localparam int CB_EDGE_BIT = 6;
    localparam int CB_NF_BIT = 7;
    localparam int CA_WGM_LSB = 0;
    localparam int FL_OVF_BIT = 0;
    localparam int FL_CAP_BIT = 5;
    localparam int CMP_SEL_BIT = 2;
    // --------------------------------------------------------------
    // writable bit masks, reset values
    // --------------------------------------------------------------
    localparam logic [7:0] MASK_CTRL_A = 8'h03;
    localparam logic [7:0] MASK_CTRL_B = 8'hDF;
    localparam logic [7:0] MASK_FLAGS = 8'h21;
    localparam logic [7:0] MASK_CMP_CS = 8'h04;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;
    // --------------------------------------------------------------
    // count limits and modes
    // --------------------------------------------------------------
    localparam logic [15:0] CNT_BOTTOM = 16'h0000;
    localparam logic [15:0] CNT_MAX = 16'hFFFF;
    localparam logic [15:0] TOP_8BIT = 16'h00FF;
    localparam logic [15:0] TOP_9BIT = 16'h01FF;
    localparam logic [15:0] TOP_10BIT = 16'h03FF;
    localparam logic [3:0] WGM_PC_CAP = 4'h8;
    localparam logic [3:0] WGM_PFC_CAP = 4'hA;
    localparam logic [3:0] WGM_CTC_CAP = 4'hC;
    localparam logic [3:0] WGM_FAST_CAP = 4'hE;
    localparam logic [2:0] CS_STOP = 3'h0;
    localparam logic [2:0] CS_EXT_FALL = 3'h6;
    localparam logic [2:0] CS_EXT_RISE = 3'h7;
    localparam int NF_SAMPLES = 4;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : tcu_pkg

// ==== src/tcu_timer.sv ====
// 16-bit timer counter with input capture, axi4-lite slave
// assumes pins arrive asynchronously; acks come from the irq controller
// Functional notes
// - counter is two byte locations; low read/write moves through a latch.
// - counter clears, increments or decrements on each timer tick by mode.
// - clock select zero produces no tick; counter stays stopped.
// - software reads and writes the counter with or without ticks.
// - software counter write beats clear or count in the same cycle.
// - three-bit clock select in control b picks the tick source.
// - four-bit waveform mode split over control a and control b.
// - overflow flag set at the mode's point and may request interrupt.
// - matching trigger edge copies the full counter into capture value.
// - capture flag set with the copy; irq when capture enable is one.
// - capture flag clears on interrupt execution or on writing one.
// - capture low read loads latch with high byte; high read returns it.
// - capture value writable only in capture-top modes, high byte first.
// - trigger from pin, or comparator output when select bit is set.
// - changing trigger source may capture; software clears flag after.
// - filter changes output only when four consecutive samples agree.
// - filter adds four system cycles and runs on the system clock.
// - edge capture disabled in capture-top waveform modes; filter keeps sampling.
// - a new capture overwrites the capture value even if unread.
// - software driving the capture pin port can trigger a capture.
// - latch keeps its value across low-byte writes for reuse.
// - bottom 0x0000, max 0xFFFF; tops 0x00FF, 0x01FF, 0x03FF, 0xFFFF or register.
`timescale 1ns/1ps
`default_nettype none
module tcu_timer #(
    parameter int ADDR_W = 6,
    parameter int PRESC_W = 10
) (
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [ADDR_W-1:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic capture_pin_i,
    input wire logic comparator_output_i,
    input wire logic ext_clk_pin_i,
    input wire logic capture_ack_i,
    input wire logic overflow_ack_i,
    output logic capture_irq_o,
    output logic overflow_irq_o
);
    // --------------------------------------------------------------
    // state
    // --------------------------------------------------------------
    typedef struct packed {
        logic [15:0] count_value;
        logic [7:0] temp;
        logic [15:0] capture_value;
        logic [7:0] control_a;
        logic [7:0] control_b;
        logic [7:0] comparator_ctrl_status;
        logic [7:0] flags;
        logic [7:0] irq_en;
        logic dir_down;
        logic [PRESC_W-1:0] presc;
        logic pin_s1;
        logic pin_s2;
        logic cmp_s1;
        logic cmp_s2;
        logic ext_s1;
        logic ext_s2;
        logic ext_prev;
        logic [3:0] samples;
        logic filt;
        logic edge_prev;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [7:0] rdata;
        logic [1:0] rresp;
    } tcu_state_t;

    tcu_state_t st;
    tcu_state_t next_st;

    logic [3:0] wgm;
    logic [2:0] clk_sel;
    logic cap_top;
    logic updown;
    logic ctc;
    logic [15:0] top;
    logic tick;
    logic trig_raw;
    logic trig_in;
    logic cap_event;
    logic wr_go;
    logic rd_go;
    logic [5:0] waddr;
    logic [5:0] raddr;
    logic [7:0] wbyte;
    logic wr_cnt_lo;
    logic rd_cnt_lo;

    // --------------------------------------------------------------
    // mode decode
    // --------------------------------------------------------------
    assign wgm = {st.control_b[tcu_pkg::CB_WGM_LSB +: 2],
                  st.control_a[tcu_pkg::CA_WGM_LSB +: 2]};
    assign clk_sel = st.control_b[tcu_pkg::CB_CS_LSB +: 3];
    assign cap_top = (wgm == tcu_pkg::WGM_PC_CAP)
        || (wgm == tcu_pkg::WGM_PFC_CAP)
        || (wgm == tcu_pkg::WGM_CTC_CAP)
        || (wgm == tcu_pkg::WGM_FAST_CAP);
    assign updown = (wgm == 4'h1) || (wgm == 4'h2) || (wgm == 4'h3)
        || (wgm == tcu_pkg::WGM_PC_CAP)
        || (wgm == tcu_pkg::WGM_PFC_CAP);
    assign ctc = (wgm == tcu_pkg::WGM_CTC_CAP);

    always_comb
    begin
        case (wgm)
            4'h1, 4'h5: top = tcu_pkg::TOP_8BIT;
            4'h2, 4'h6: top = tcu_pkg::TOP_9BIT;
            4'h3, 4'h7: top = tcu_pkg::TOP_10BIT;
            tcu_pkg::WGM_PC_CAP, tcu_pkg::WGM_PFC_CAP,
            tcu_pkg::WGM_CTC_CAP, tcu_pkg::WGM_FAST_CAP:
                top = st.capture_value;
            default: top = tcu_pkg::CNT_MAX;
        endcase
    end

    // --------------------------------------------------------------
    // tick source
    // --------------------------------------------------------------
    // prescaler taps are simple powers of two off one shared counter
    always_comb
    begin
        case (clk_sel)
            tcu_pkg::CS_STOP: tick = 1'b0;
            3'h1: tick = 1'b1;
            3'h2: tick = &st.presc[2:0];
            3'h3: tick = &st.presc[5:0];
            3'h4: tick = &st.presc[7:0];
            3'h5: tick = &st.presc[PRESC_W-1:0];
            tcu_pkg::CS_EXT_FALL: tick = st.ext_prev && !st.ext_s2;
            tcu_pkg::CS_EXT_RISE: tick = !st.ext_prev && st.ext_s2;
            default: tick = 1'b0;
        endcase
    end

    // --------------------------------------------------------------
    // capture trigger path
    // --------------------------------------------------------------
    // the pin is sampled as-is, so a port write drives it too
    assign trig_raw = st.comparator_ctrl_status[tcu_pkg::CMP_SEL_BIT]
        ? st.cmp_s2 : st.pin_s2;
    assign trig_in = st.control_b[tcu_pkg::CB_NF_BIT]
        ? st.filt : trig_raw;
    assign cap_event = !cap_top && (st.control_b[tcu_pkg::CB_EDGE_BIT]
        ? (trig_in && !st.edge_prev)
        : (!trig_in && st.edge_prev));

    // --------------------------------------------------------------
    // bus handshake
    // --------------------------------------------------------------
    // address and data are taken together; one write in flight
    assign wr_go = s_axi_awvalid_i && s_axi_wvalid_i && !st.bvalid;
    assign rd_go = s_axi_arvalid_i && !st.rvalid;
    assign s_axi_awready_o = wr_go;
    assign s_axi_wready_o = wr_go;
    assign s_axi_arready_o = !st.rvalid;
    assign waddr = {s_axi_awaddr_i[5:2], 2'b00};
    assign raddr = {s_axi_araddr_i[5:2], 2'b00};
    assign wbyte = s_axi_wdata_i[7:0];
    assign wr_cnt_lo = wr_go && s_axi_wstrb_i[0]
        && (waddr == tcu_pkg::OFF_COUNT_LO);
    assign rd_cnt_lo = rd_go && (raddr == tcu_pkg::OFF_COUNT_LO);

    assign s_axi_bvalid_o = st.bvalid;
    assign s_axi_bresp_o = st.bresp;
    assign s_axi_rvalid_o = st.rvalid;
    assign s_axi_rdata_o = {24'h000000, st.rdata};
    assign s_axi_rresp_o = st.rresp;
    assign capture_irq_o = st.flags[tcu_pkg::FL_CAP_BIT]
        && st.irq_en[tcu_pkg::FL_CAP_BIT];
    assign overflow_irq_o = st.flags[tcu_pkg::FL_OVF_BIT]
        && st.irq_en[tcu_pkg::FL_OVF_BIT];

    // --------------------------------------------------------------
    // next state
    // --------------------------------------------------------------
    always_comb
    begin
        logic ovf_set;
        logic mapped;
        ovf_set = 1'b0;
        mapped = 1'b1;
        next_st = st;
        next_st.presc = (clk_sel == tcu_pkg::CS_STOP)
            ? '0 : st.presc + 1'b1;
        next_st.pin_s1 = capture_pin_i;
        next_st.pin_s2 = st.pin_s1;
        next_st.cmp_s1 = comparator_output_i;
        next_st.cmp_s2 = st.cmp_s1;
        next_st.ext_s1 = ext_clk_pin_i;
        next_st.ext_s2 = st.ext_s1;
        next_st.ext_prev = st.ext_s2;

        // four samples must agree before the filter moves
        // newest sample counts, so the filter adds four cycles
        next_st.samples = {st.samples[2:0], trig_raw};
        if (next_st.samples == 4'hF)
            next_st.filt = 1'b1;
        else if (next_st.samples == 4'h0)
            next_st.filt = 1'b0;
        next_st.edge_prev = trig_in;

        // counter sequence
        if (tick)
        begin
            if (updown)
            begin
                if (!st.dir_down)
                begin
                    if (st.count_value >= top)
                    begin
                        next_st.dir_down = 1'b1;
                        next_st.count_value = st.count_value - 1'b1;
                    end
                    else
                        next_st.count_value = st.count_value + 1'b1;
                end
                else if (st.count_value == tcu_pkg::CNT_BOTTOM)
                begin
                    next_st.dir_down = 1'b0;
                    next_st.count_value = st.count_value + 1'b1;
                    ovf_set = 1'b1;
                end
                else
                    next_st.count_value = st.count_value - 1'b1;
            end
            else
            begin
                next_st.dir_down = 1'b0;
                if (st.count_value == top)
                    next_st.count_value = tcu_pkg::CNT_BOTTOM;
                else
                    next_st.count_value = st.count_value + 1'b1;
                ovf_set = ctc
                    ? (st.count_value == tcu_pkg::CNT_MAX)
                    : (st.count_value == top);
            end
        end

        // capture overwrites, unread or not
        if (cap_event)
            next_st.capture_value = st.count_value;

        // write response
        if (st.bvalid && s_axi_bready_i)
            next_st.bvalid = 1'b0;
        if (wr_go)
        begin
            next_st.bvalid = 1'b1;
            case (waddr)
                tcu_pkg::OFF_COUNT_LO, tcu_pkg::OFF_COUNT_HI,
                tcu_pkg::OFF_CAPT_LO, tcu_pkg::OFF_CAPT_HI,
                tcu_pkg::OFF_CTRL_A, tcu_pkg::OFF_CTRL_B,
                tcu_pkg::OFF_FLAGS, tcu_pkg::OFF_IRQ_EN,
                tcu_pkg::OFF_CMP_CS: mapped = 1'b1;
                default: mapped = 1'b0;
            endcase
            next_st.bresp = mapped
                ? tcu_pkg::RESP_OKAY : tcu_pkg::RESP_SLVERR;
        end

        // read: low-byte reads load the shared latch
        if (st.rvalid && s_axi_rready_i)
            next_st.rvalid = 1'b0;
        if (rd_go)
        begin
            next_st.rvalid = 1'b1;
            next_st.rresp = tcu_pkg::RESP_OKAY;
            case (raddr)
                tcu_pkg::OFF_COUNT_LO:
                begin
                    next_st.rdata = st.count_value[7:0];
                    next_st.temp = st.count_value[15:8];
                end
                tcu_pkg::OFF_CAPT_LO:
                begin
                    next_st.rdata = st.capture_value[7:0];
                    next_st.temp = st.capture_value[15:8];
                end
                tcu_pkg::OFF_COUNT_HI, tcu_pkg::OFF_CAPT_HI:
                    next_st.rdata = st.temp;
                tcu_pkg::OFF_CTRL_A: next_st.rdata = st.control_a;
                tcu_pkg::OFF_CTRL_B: next_st.rdata = st.control_b;
                tcu_pkg::OFF_FLAGS: next_st.rdata = st.flags;
                tcu_pkg::OFF_IRQ_EN: next_st.rdata = st.irq_en;
                tcu_pkg::OFF_CMP_CS:
                    next_st.rdata = st.comparator_ctrl_status;
                default:
                begin
                    next_st.rdata = tcu_pkg::RST_BYTE;
                    next_st.rresp = tcu_pkg::RESP_SLVERR;
                end
            endcase
        end

        // register writes; a counter write wins over counting
        if (wr_go && s_axi_wstrb_i[0])
        begin
            case (waddr)
                tcu_pkg::OFF_COUNT_LO:
                    next_st.count_value = {st.temp, wbyte};
                tcu_pkg::OFF_COUNT_HI, tcu_pkg::OFF_CAPT_HI:
                    next_st.temp = wbyte;
                tcu_pkg::OFF_CAPT_LO:
                    if (cap_top)
                        next_st.capture_value = {st.temp, wbyte};
                tcu_pkg::OFF_CTRL_A:
                    next_st.control_a = wbyte & tcu_pkg::MASK_CTRL_A;
                tcu_pkg::OFF_CTRL_B:
                    next_st.control_b = wbyte & tcu_pkg::MASK_CTRL_B;
                tcu_pkg::OFF_IRQ_EN:
                    next_st.irq_en = wbyte & tcu_pkg::MASK_FLAGS;
                tcu_pkg::OFF_CMP_CS:
                    next_st.comparator_ctrl_status =
                        wbyte & tcu_pkg::MASK_CMP_CS;
                default: ;
            endcase
        end

        // flags: write one or ack clears, a new event wins
        if (wr_go && s_axi_wstrb_i[0] && waddr == tcu_pkg::OFF_FLAGS)
            next_st.flags = st.flags & ~(wbyte & tcu_pkg::MASK_FLAGS);
        if (capture_ack_i)
            next_st.flags[tcu_pkg::FL_CAP_BIT] = 1'b0;
        if (overflow_ack_i)
            next_st.flags[tcu_pkg::FL_OVF_BIT] = 1'b0;
        if (cap_event)
            next_st.flags[tcu_pkg::FL_CAP_BIT] = 1'b1;
        if (ovf_set && !wr_cnt_lo)
            next_st.flags[tcu_pkg::FL_OVF_BIT] = 1'b1;
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            st <= '0;
            st.count_value <= tcu_pkg::RST_WORD;
            st.capture_value <= tcu_pkg::RST_WORD;
            st.bresp <= tcu_pkg::RESP_OKAY;
            st.rresp <= tcu_pkg::RESP_OKAY;
        end
        else
            st <= next_st;
    end

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!reset_n_i);

    sequence s_lo_write;
        wr_cnt_lo;
    endsequence
    sequence s_capture;
        cap_event;
    endsequence

    a_stop_holds: assert property (
        (clk_sel == tcu_pkg::CS_STOP) && !wr_cnt_lo
        |=> $stable(st.count_value))
        else $error("counter moved while stopped");
    a_write_wins: assert property (
        s_lo_write |=> st.count_value == {$past(st.temp), $past(wbyte)})
        else $error("counter write lost");
    a_capture_copy: assert property (
        s_capture |=> st.capture_value == $past(st.count_value))
        else $error("capture value not copied");
    a_capture_flag: assert property (
        s_capture ##1 st.irq_en[tcu_pkg::FL_CAP_BIT]
        |-> st.flags[tcu_pkg::FL_CAP_BIT] && capture_irq_o)
        else $error("capture flag or irq missing");
    a_ack_clears: assert property (
        capture_ack_i && !cap_event
        |=> !st.flags[tcu_pkg::FL_CAP_BIT])
        else $error("capture flag not cleared");
    a_lo_read_latch: assert property (
        rd_go && raddr == tcu_pkg::OFF_CAPT_LO
        && !(wr_go && s_axi_wstrb_i[0] && (waddr == tcu_pkg::OFF_COUNT_HI
        || waddr == tcu_pkg::OFF_CAPT_HI))
        |=> st.temp == $past(st.capture_value[15:8]))
        else $error("latch not loaded on low read");
    a_filter_agree: assert property (
        $changed(st.filt)
        |-> st.samples == 4'hF || st.samples == 4'h0)
        else $error("filter moved without agreement");
    a_topmode_nocap: assert property (
        cap_top |-> !cap_event)
        else $error("capture in capture-top mode");
    a_hi_retain: assert property (
        s_lo_write ##0 !rd_go |=> $stable(st.temp))
        else $error("latch changed on low write");
    a_dir_bottom: assert property (
        tick && updown && st.dir_down
        && st.count_value == tcu_pkg::CNT_BOTTOM && !wr_cnt_lo
        |=> !st.dir_down && st.flags[tcu_pkg::FL_OVF_BIT])
        else $error("no turn at bottom");
endmodule : tcu_timer
`default_nettype wire

// ==== sim/tcu_cpu_model.sv ====
// processor-side axi4-lite master for the timer register block
// assumes one slave on clk_i; the bench calls wr and rd one at a time
`timescale 1ns/1ps
`default_nettype none
module tcu_cpu_model (
    input wire logic clk_i,
    output logic [5:0] awaddr_o,
    output logic awvalid_o,
    input wire logic awready_i,
    output logic [31:0] wdata_o,
    output logic [3:0] wstrb_o,
    output logic wvalid_o,
    input wire logic wready_i,
    input wire logic [1:0] bresp_i,
    input wire logic bvalid_i,
    output logic bready_o,
    output logic [5:0] araddr_o,
    output logic arvalid_o,
    input wire logic arready_i,
    input wire logic [31:0] rdata_i,
    input wire logic [1:0] rresp_i,
    input wire logic rvalid_i,
    output logic rready_o,
    output logic hang_o
);
    // ------------------------------------------------------------
    // byte accesses; 99 edges per access, then hang is flagged
    // ------------------------------------------------------------
    initial
    begin
        {awaddr_o, awvalid_o, wdata_o, wvalid_o, bready_o} = '0;
        {araddr_o, arvalid_o, rready_o, hang_o} = '0;
        wstrb_o = 4'h1;
    end

    task automatic wr(input logic [5:0] a, input logic [7:0] d,
        output logic [1:0] r);
        int n;
        n = 0;
        @(posedge clk_i);
        awaddr_o <= a;
        wdata_o <= {24'h000000, d};
        awvalid_o <= 1'b1;
        wvalid_o <= 1'b1;
        bready_o <= 1'b1;
        do @(posedge clk_i); while (!(awready_i && wready_i) && ++n < 99);
        awvalid_o <= 1'b0;
        wvalid_o <= 1'b0;
        while (!bvalid_i && ++n < 99) @(posedge clk_i);
        r = bresp_i;
        bready_o <= 1'b0;
        if (n >= 99) hang_o = 1'b1;
    endtask : wr

    task automatic rd(input logic [5:0] a, output logic [31:0] d,
        output logic [1:0] r);
        int n;
        n = 0;
        @(posedge clk_i);
        araddr_o <= a;
        arvalid_o <= 1'b1;
        rready_o <= 1'b1;
        do @(posedge clk_i); while (!arready_i && ++n < 99);
        arvalid_o <= 1'b0;
        while (!rvalid_i && ++n < 99) @(posedge clk_i);
        d = rdata_i;
        r = rresp_i;
        rready_o <= 1'b0;
        if (n >= 99) hang_o = 1'b1;
    endtask : rd
endmodule : tcu_cpu_model
`default_nettype wire

// ==== sim/timer16_counter_input_capture_tb.sv ====
// bench for the timer counter with input capture
// assumes tcu_pkg and tcu_cpu_model compiled first
`timescale 1ns/1ps
`default_nettype none
module timer16_counter_input_capture_tb;
    localparam logic [5:0] CLO = tcu_pkg::OFF_COUNT_LO;
    localparam logic [5:0] CHI = tcu_pkg::OFF_COUNT_HI;
    localparam logic [5:0] PLO = tcu_pkg::OFF_CAPT_LO;
    localparam logic [5:0] PHI = tcu_pkg::OFF_CAPT_HI;
    localparam logic [5:0] CB = tcu_pkg::OFF_CTRL_B;
    localparam logic [5:0] FL = tcu_pkg::OFF_FLAGS;
    localparam logic [5:0] IE = tcu_pkg::OFF_IRQ_EN;
    localparam logic [5:0] CM = tcu_pkg::OFF_CMP_CS;
    logic clk_i, rst_n, cap_pin, cmp_out, ack, irq, oirq, hang_o;
    logic awvalid_o, wvalid_o, bready_o, arvalid_o, rready_o;
    logic awready_i, wready_i, bvalid_i, arready_i, rvalid_i;
    logic [5:0] awaddr_o, araddr_o;
    logic [31:0] wdata_o, rdata_i, d1, d2;
    logic [3:0] wstrb_o;
    logic [1:0] bresp_i, rresp_i, rr;
    int fails = 0;
    int n_checks = 0;

    tcu_cpu_model u_cpu (
        .clk_i(clk_i), .awaddr_o(awaddr_o), .awvalid_o(awvalid_o),
        .awready_i(awready_i), .wdata_o(wdata_o), .wstrb_o(wstrb_o),
        .wvalid_o(wvalid_o), .wready_i(wready_i), .bresp_i(bresp_i),
        .bvalid_i(bvalid_i), .bready_o(bready_o), .araddr_o(araddr_o),
        .arvalid_o(arvalid_o), .arready_i(arready_i), .rdata_i(rdata_i),
        .rresp_i(rresp_i), .rvalid_i(rvalid_i), .rready_o(rready_o),
        .hang_o(hang_o)
    );

    tcu_timer u_dut (
        .ref_clk_i(clk_i), .reset_n_i(rst_n),
        .s_axi_awaddr_i(awaddr_o), .s_axi_awvalid_i(awvalid_o),
        .s_axi_awready_o(awready_i), .s_axi_wdata_i(wdata_o),
        .s_axi_wstrb_i(wstrb_o), .s_axi_wvalid_i(wvalid_o),
        .s_axi_wready_o(wready_i), .s_axi_bresp_o(bresp_i),
        .s_axi_bvalid_o(bvalid_i), .s_axi_bready_i(bready_o),
        .s_axi_araddr_i(araddr_o), .s_axi_arvalid_i(arvalid_o),
        .s_axi_arready_o(arready_i), .s_axi_rdata_o(rdata_i),
        .s_axi_rresp_o(rresp_i), .s_axi_rvalid_o(rvalid_i),
        .s_axi_rready_i(rready_o), .capture_pin_i(cap_pin),
        .comparator_output_i(cmp_out), .ext_clk_pin_i(1'b0),
        .capture_ack_i(ack), .overflow_ack_i(1'b0),
        .capture_irq_o(irq), .overflow_irq_o(oirq)
    );

    // ------------------------------------------------------------
    // checking and bus helpers
    // ------------------------------------------------------------
    task automatic close_out();
        if (u_cpu.hang_o) fails++;
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : close_out

    task automatic chk(input string nm, input logic [33:0] s, e);
        n_checks++;
        if (s !== e)
        begin
            fails++;
            $display("MISMATCH %s exp %h got %h", nm, e, s);
        end
    endtask : chk

    task automatic w(input logic [5:0] a, input logic [7:0] d);
        logic [1:0] r;
        u_cpu.wr(a, d, r);
        chk("wr resp", {32'h0, r}, {32'h0, tcu_pkg::RESP_OKAY});
        if (u_cpu.hang_o) close_out();
    endtask : w

    task automatic rc(input logic [5:0] a, input logic [7:0] e,
        input string nm);
        logic [31:0] d;
        logic [1:0] r;
        u_cpu.rd(a, d, r);
        chk(nm, {r, d}, {tcu_pkg::RESP_OKAY, 24'h000000, e});
        if (u_cpu.hang_o) close_out();
    endtask : rc

    initial
    begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    // ------------------------------------------------------------
    // main sequence; counter stopped so captures are exact
    // ------------------------------------------------------------
    initial
    begin
        {cap_pin, cmp_out, ack} = 3'h0;
        rst_n = 1'b0;
        repeat (2) @(posedge clk_i);
        rst_n <= 1'b1;
        rc(CB, 8'h00, "ctrl_b");
        rc(CLO, 8'h00, "stopped");
        w(CHI, 8'h12);
        w(CLO, 8'h34);
        rc(CLO, 8'h34, "cnt lo");
        rc(CHI, 8'h12, "cnt hi");
        w(CHI, 8'h7E);
        w(CLO, 8'h01);
        w(CLO, 8'h02);
        rc(CLO, 8'h02, "reuse lo");
        rc(CHI, 8'h7E, "reuse hi");
        w(IE, 8'h20);
        w(CB, 8'h40);
        @(posedge clk_i) cap_pin <= 1'b1;
        repeat (3) @(posedge clk_i);
        rc(FL, 8'h20, "cap flag");
        chk("cap irq", {33'h0, irq}, 34'h1);
        rc(PLO, 8'h02, "cap lo");
        rc(PHI, 8'h7E, "cap hi");
        w(FL, 8'h20);
        rc(FL, 8'h00, "w1c");
        @(posedge clk_i) cap_pin <= 1'b0;
        repeat (3) @(posedge clk_i);
        rc(FL, 8'h00, "fall");
        w(CLO, 8'h44);
        @(posedge clk_i) cap_pin <= 1'b1;
        repeat (3) @(posedge clk_i);
        @(posedge clk_i) ack <= 1'b1;
        @(posedge clk_i) ack <= 1'b0;
        rc(FL, 8'h00, "ack");
        rc(PLO, 8'h44, "overwrite");
        w(CB, 8'h00);
        w(FL, 8'h20);
        w(CM, 8'h04);
        rc(FL, 8'h20, "src switch");
        w(CB, 8'h40);
        w(FL, 8'h20);
        @(posedge clk_i) cmp_out <= 1'b1;
        repeat (3) @(posedge clk_i);
        rc(FL, 8'h20, "cmp trig");
        w(CM, 8'h00);
        w(CB, 8'hC0);
        w(FL, 8'h20);
        @(posedge clk_i) cap_pin <= 1'b0;
        repeat (2) @(posedge clk_i);
        cap_pin <= 1'b1;
        repeat (12) @(posedge clk_i);
        rc(FL, 8'h00, "glitch");
        @(posedge clk_i) cap_pin <= 1'b0;
        repeat (12) @(posedge clk_i);
        cap_pin <= 1'b1;
        repeat (6) @(posedge clk_i);
        @(negedge clk_i) chk("nf delay", {33'h0, irq}, 34'h0);
        @(negedge clk_i) chk("nf edge irq", {33'h0, irq}, 34'h1);
        rc(FL, 8'h20, "nf edge");
        w(PHI, 8'h33);
        w(PLO, 8'h55);
        rc(PLO, 8'h44, "cap ro");
        w(CB, 8'h18);
        w(PHI, 8'h33);
        w(PLO, 8'h55);
        rc(PLO, 8'h55, "top lo");
        rc(PHI, 8'h33, "top hi");
        w(FL, 8'h20);
        @(posedge clk_i) cap_pin <= 1'b0;
        repeat (3) @(posedge clk_i);
        rc(FL, 8'h00, "no cap");
        w(tcu_pkg::OFF_CTRL_A, 8'h01);
        w(IE, 8'h21);
        w(CHI, 8'h00);
        w(CLO, 8'hF0);
        w(CB, 8'h01);
        repeat (300) @(posedge clk_i);
        rc(FL, 8'h01, "ovf bottom");
        chk("ovf irq", {33'h0, oirq}, 34'h1);
        u_cpu.rd(CLO, d1, rr);
        u_cpu.rd(CLO, d2, rr);
        chk("runs", {33'h0, d1 !== d2}, 34'h1);
        u_cpu.rd(6'h24, d1, rr);
        chk("unmapped", {32'h0, rr}, {32'h0, tcu_pkg::RESP_SLVERR});
        close_out();
    end
endmodule : timer16_counter_input_capture_tb
`default_nettype wire
